// [logic/wake_pkg.sv]
// Purpose: shared constants and types for the wake identifier filter channel
// Assumes: 100 MHz system clock
// Notes: timing counts derive from times in their own units
package wake_pkg;
	localparam int unsigned CLK_HZ           = 100000000;
	localparam int unsigned DEF_BAUD         = 500000;
	localparam int unsigned STD_ID_W         = 11;
	localparam int unsigned EXT_ID_W         = 29;
	localparam int unsigned DEF_TIMEOUT_MS   = 1000;
	localparam int unsigned TIMEOUT_CYCLES   = (CLK_HZ / 1000) * DEF_TIMEOUT_MS;
	localparam int unsigned BIT_DIV_DEFAULT  = CLK_HZ / DEF_BAUD;
	localparam int unsigned HOLD_DEPTH       = 4;
	localparam logic [28:0] RST_IDENT        = 29'h0000000;
	localparam logic [28:0] RST_MASK         = 29'h0000000;

	typedef enum logic [1:0] {
		WAKE_DISABLED = 2'b00,
		WAKE_BASIC    = 2'b01,
		WAKE_LOSSLESS = 2'b10,
		WAKE_KEEP     = 2'b11
	} wake_mode_t;

	typedef enum logic [1:0] {
		PWR_OFF     = 2'b00,
		PWR_WAKING  = 2'b01,
		PWR_RUN     = 2'b10
	} pwr_state_t;
endpackage

// [logic/frame_if.sv]
// Purpose: carries received frames into the hold memory
// Assumes: single clock domain
// Notes: one word per frame: extended flag and identifier
`timescale 1ns/1ps
interface frame_if;
	logic        wr_en;
	logic [29:0] wr_data;
	logic        rd_en;
	logic [29:0] rd_data;
	logic        rd_valid;
	logic        full;
	logic        empty;
	modport owner (output wr_en, output wr_data, output rd_en,
		input rd_data, input rd_valid, input full, input empty);
	modport mem (input wr_en, input wr_data, input rd_en,
		output rd_data, output rd_valid, output full, output empty);
endinterface

// [logic/frame_hold_mem.sv]
// Purpose: small memory that keeps frames received while the logger wakes
// Assumes: reader never reads when empty; a write when full is dropped
// Notes: read data comes out of a register
`timescale 1ns/1ps
module frame_hold_mem #(
	parameter int unsigned DEPTH = wake_pkg::HOLD_DEPTH
) (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	frame_if.mem      port
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [29:0] store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;

	assign port.full  = (count == (AW+1)'(DEPTH));
	assign port.empty = (count == '0);

	always_ff @(posedge clk_i)
	begin
		if (port.wr_en && !port.full)
			store[wr_ptr] <= port.wr_data;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_ptr        <= '0;
			rd_ptr        <= '0;
			count         <= '0;
			port.rd_data  <= '0;
			port.rd_valid <= 1'b0;
		end
		else
		begin
			port.rd_valid <= 1'b0;
			if (port.wr_en && !port.full)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (port.rd_en && !port.empty)
			begin
				port.rd_data  <= store[rd_ptr];
				port.rd_valid <= 1'b1;
				rd_ptr        <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(port.wr_en && !port.full)
				- (AW+1)'(port.rd_en && !port.empty);
		end
	end
endmodule

// [logic/can_wake_id_filter.sv]
// Purpose: one classic CAN channel's bit timing, silent mode and wake filter
// Assumes: frames arrive decoded as a pulse with identifier and format flag
// Notes: inactivity timeout is a parameter so simulation can shorten it
//
// Summary of operation
// - bit rate selectable per channel, default 500k
// - all bus nodes must share bit rate
// - normal setting lets channel drive bus
// - silent mode: observe only, never drive
// - classic CAN only, no fast data phase
// - inactive after timeout; only then shutdown allowed
// - timeout logs entry, raises alert until acknowledged
// - disabled mode: frames never start logger
// - basic mode: wake, early frames may drop
// - lossless mode: frames kept, waking included, up to HOLD_DEPTH held before logger runs
// - keep awake: ignition starts, all sources stop
// - match identifier bits where mask is one
// - identifier and mask standard or extended format
// - all-zero mask accepts every frame whose format is extended when the identifier or mask is extended, else standard
// - ident 22 mask 28: bits 4,2 set, 3 clear
// - qualifying frames keep running; absence stops logger
`timescale 1ns/1ps
module can_wake_id_filter #(
	parameter int unsigned TIMEOUT_CYCLES = wake_pkg::TIMEOUT_CYCLES,
	parameter int unsigned HOLD_DEPTH     = wake_pkg::HOLD_DEPTH
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// configuration
	input  wire logic [15:0] bit_div_i,
	input  wire logic        normal_mode_i,
	input  wire logic [1:0]  wake_mode_i,
	input  wire logic [28:0] ident_value_i,
	input  wire logic        ident_value_ext_i,
	input  wire logic [28:0] ident_compare_mask_i,
	input  wire logic        ident_mask_ext_i,
	// bus pins and controller side
	input  wire logic        can_rx_i,
	input  wire logic        ctrl_tx_i,
	input  wire logic        ctrl_tx_en_i,
	output logic             can_tx_o,
	output logic             bit_tick_o,
	output logic             rx_sample_o,
	// decoded frames
	input  wire logic        frame_valid_i,
	input  wire logic [28:0] frame_ident_i,
	input  wire logic        frame_ext_i,
	// wake sources and power
	input  wire logic        ignition_i,
	input  wire logic        other_wake_i,
	input  wire logic        logger_ready_i,
	input  wire logic        alert_ack_i,
	output logic             logger_on_o,
	output logic             shutdown_ok_o,
	output logic             any_wake_source_o,
	// captured frames and alerts
	output logic             cap_valid_o,
	output logic [29:0]      cap_data_o,
	output logic             log_entry_o,
	output logic             alert_o
);
	localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);

	frame_if fifo ();
	wake_pkg::pwr_state_t state;
	wake_pkg::pwr_state_t next_state;
	wake_pkg::wake_mode_t mode;
	logic [15:0] div_cnt;
	logic [TW-1:0] idle_cnt;
	logic qualify;
	logic timed_out;
	logic active_wake;

	// identifier compare with mask and format check
	function automatic logic id_match(input logic [28:0] id, input logic ext,
		input logic [28:0] val, input logic [28:0] msk, input logic fext);
		logic [28:0] m;
		m = fext ? msk : {18'h00000, msk[10:0]};
		id_match = (ext == fext) && (((id ^ val) & m) == 29'h0000000);
	endfunction

	assign mode    = wake_pkg::wake_mode_t'(wake_mode_i);
	assign qualify = frame_valid_i && id_match(frame_ident_i, frame_ext_i, ident_value_i,
		ident_compare_mask_i, ident_value_ext_i | ident_mask_ext_i);
	assign active_wake = (mode == wake_pkg::WAKE_BASIC) || (mode == wake_pkg::WAKE_LOSSLESS);
	assign timed_out   = (idle_cnt == TW'(TIMEOUT_CYCLES));

	// bit-rate divider gives one-cycle sample tick; classic rate only
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			div_cnt    <= 16'h0000;
			bit_tick_o <= 1'b0;
		end
		else if (div_cnt >= bit_div_i - 16'h0001)
		begin
			div_cnt    <= 16'h0000;
			bit_tick_o <= 1'b1;
		end
		else
		begin
			div_cnt    <= div_cnt + 16'h0001;
			bit_tick_o <= 1'b0;
		end
	end

	// sample and transmit only on the tick; recessive unless normal mode
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			can_tx_o    <= 1'b1;
			rx_sample_o <= 1'b1;
		end
		else if (bit_tick_o)
		begin
			rx_sample_o <= can_rx_i;
			if (normal_mode_i && ctrl_tx_en_i)
				can_tx_o <= ctrl_tx_i;
			else
				can_tx_o <= 1'b1;
		end
	end

	// inactivity counter restarts on each qualifying frame
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			idle_cnt <= '0;
		else if (qualify || state == wake_pkg::PWR_OFF)
			idle_cnt <= '0;
		else if (!timed_out)
			idle_cnt <= idle_cnt + 1'b1;
	end

	always_comb
	begin
		next_state = state;
		case (state)
			wake_pkg::PWR_OFF:
				if (mode == wake_pkg::WAKE_KEEP ? ignition_i : (active_wake && qualify))
					next_state = wake_pkg::PWR_WAKING;
			wake_pkg::PWR_WAKING:
				if (logger_ready_i)
					next_state = wake_pkg::PWR_RUN;
			wake_pkg::PWR_RUN:
				if (mode == wake_pkg::WAKE_KEEP)
				begin
					if (!ignition_i && !other_wake_i && timed_out)
						next_state = wake_pkg::PWR_OFF;
				end
				else if (timed_out)
					next_state = wake_pkg::PWR_OFF;
			default:
				next_state = wake_pkg::PWR_OFF;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state <= wake_pkg::PWR_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			logger_on_o       <= 1'b0;
			shutdown_ok_o     <= 1'b1;
			any_wake_source_o <= 1'b0;
		end
		else
		begin
			logger_on_o       <= (next_state != wake_pkg::PWR_OFF);
			shutdown_ok_o     <= (next_state == wake_pkg::PWR_OFF);
			any_wake_source_o <= ignition_i || other_wake_i || !timed_out && state != wake_pkg::PWR_OFF;
		end
	end

	// timeout event: one-cycle log pulse and alert held until acknowledge
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			log_entry_o <= 1'b0;
			alert_o     <= 1'b0;
		end
		else
		begin
			log_entry_o <= (state == wake_pkg::PWR_RUN) && (next_state == wake_pkg::PWR_OFF)
				&& timed_out;
			if ((state == wake_pkg::PWR_RUN) && (next_state == wake_pkg::PWR_OFF) && timed_out)
				alert_o <= 1'b1;
			else if (alert_ack_i)
				alert_o <= 1'b0;
		end
	end

	// lossless mode holds frames from the waking one until the logger runs;
	// live frames queue behind any backlog so order is kept; a frame that arrives while the HOLD_DEPTH store is full is lost
	assign fifo.wr_en   = frame_valid_i && (mode == wake_pkg::WAKE_LOSSLESS)
		&& (state == wake_pkg::PWR_WAKING || (state == wake_pkg::PWR_OFF && qualify)
		|| (state == wake_pkg::PWR_RUN && (!fifo.empty || fifo.rd_valid)));
	assign fifo.wr_data = {frame_ext_i, frame_ident_i};
	assign fifo.rd_en   = (state == wake_pkg::PWR_RUN) && !fifo.empty;

	frame_hold_mem #(
		.DEPTH (HOLD_DEPTH)
	) u_hold (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.port      (fifo)
	);

	// running: live frames pass once backlog drains; basic mode drops wake frames
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cap_valid_o <= 1'b0;
			cap_data_o  <= 30'h00000000;
		end
		else if (fifo.rd_valid)
		begin
			cap_valid_o <= 1'b1;
			cap_data_o  <= fifo.rd_data;
		end
		else
		begin
			cap_valid_o <= frame_valid_i && (state == wake_pkg::PWR_RUN)
				&& fifo.empty && !fifo.rd_valid;
			cap_data_o  <= {frame_ext_i, frame_ident_i};
		end
	end
endmodule

// [testbench/can_wake_chk.sv]
// Purpose: concurrent checks on the wake filter channel ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: period check only when the divider is set to 8
`timescale 1ns/1ps
module can_wake_chk (
	input wire logic clk_i, reset_n_i, normal_mode_i, ident_value_ext_i, ident_mask_ext_i,
	input wire logic frame_valid_i, frame_ext_i, ignition_i, other_wake_i, alert_ack_i,
	input wire logic [15:0] bit_div_i,
	input wire logic [1:0]  wake_mode_i,
	input wire logic [28:0] ident_compare_mask_i,
	input wire logic can_tx_o, bit_tick_o, logger_on_o, shutdown_ok_o, alert_o, log_entry_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_tick; bit_tick_o && bit_div_i == 16'h0008 |=> !bit_tick_o[*7] ##1 bit_tick_o;
	endproperty
	a_tick: assert property (p_tick) else $error("bit tick period wrong");
	property p_silent; bit_tick_o && !normal_mode_i && $past(!normal_mode_i) |=> can_tx_o;
	endproperty
	a_silent: assert property (p_silent) else $error("bus driven in silent mode");
	property p_sticky; alert_o && !alert_ack_i |=> alert_o; endproperty
	a_sticky: assert property (p_sticky) else $error("alert dropped without ack");
	property p_cause; $rose(alert_o) |-> log_entry_o || $past(log_entry_o); endproperty
	a_cause: assert property (p_cause) else $error("alert without log entry");
	property p_pulse; log_entry_o |=> !log_entry_o; endproperty
	a_pulse: assert property (p_pulse) else $error("log entry longer than one cycle");
	property p_onoff; logger_on_o |-> !shutdown_ok_o; endproperty
	a_onoff: assert property (p_onoff) else $error("shutdown allowed while on");
	property p_off; wake_mode_i == 2'b00 && !logger_on_o && !ignition_i && !other_wake_i
		|=> !logger_on_o; endproperty
	a_off: assert property (p_off) else $error("started in disabled mode");
	property p_zero; frame_valid_i && !logger_on_o && wake_mode_i == 2'b01 && !frame_ext_i
		&& ident_compare_mask_i == 29'h0 && !ident_value_ext_i && !ident_mask_ext_i
		|=> logger_on_o; endproperty
	a_zero: assert property (p_zero) else $error("zero mask did not start");
endmodule
bind can_wake_id_filter can_wake_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.normal_mode_i(normal_mode_i), .ident_value_ext_i(ident_value_ext_i),
	.ident_mask_ext_i(ident_mask_ext_i), .frame_valid_i(frame_valid_i),
	.frame_ext_i(frame_ext_i), .ignition_i(ignition_i), .other_wake_i(other_wake_i),
	.alert_ack_i(alert_ack_i), .bit_div_i(bit_div_i), .wake_mode_i(wake_mode_i),
	.ident_compare_mask_i(ident_compare_mask_i), .can_tx_o(can_tx_o),
	.bit_tick_o(bit_tick_o), .logger_on_o(logger_on_o), .shutdown_ok_o(shutdown_ok_o),
	.alert_o(alert_o), .log_entry_o(log_entry_o));

// [testbench/can_node_model.sv]
// Purpose: other node on the bus handing decoded frames to the channel
// Assumes: frames arrive decoded, one cycle each
// Notes: identifier lines scramble between frames
`timescale 1ns/1ps
module can_node_model (
	input  wire logic   clk_i,
	output logic        rx_o,
	output logic        valid_o,
	output logic [28:0] ident_o,
	output logic        ext_o
);
	initial
	begin
		rx_o = 1'b1;
		valid_o = 1'b0;
		ident_o = 29'h0AAAAAAA;
		ext_o = 1'b0;
	end
	// classic frames only, each held one clock cycle, not timed to the bit rate
	task automatic send(input logic [28:0] id, input logic ext);
		@(posedge clk_i);
		#1;
		valid_o = 1'b1;
		ident_o = id;
		ext_o = ext;
		rx_o = 1'b0;
		@(posedge clk_i);
		#1;
		valid_o = 1'b0;
		ident_o = ~id;
		ext_o = ~ext;
		rx_o = 1'b1;
	endtask
	// bus level held between frames
	task automatic drive_rx(input logic lvl);
		@(posedge clk_i);
		#1;
		rx_o = lvl;
	endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the wake filter channel
// Assumes: timeout shortened to 50 cycles, divider set to 12 then 8
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_top;
	logic        clk_i, reset_n_i, nrm, txe, ready, ack, ign, rx, fv, fx, idx, mkx;
	logic [1:0]  mode;
	logic [28:0] idv, msk, fid;
	logic        can_tx, tick, on, alert, logd, capv;
	logic        oth, sok, aws, rxs;
	logic [15:0] div;
	logic [29:0] capd;
	int          bad_count, checks, n;
	time         t;
	can_node_model u_node (.clk_i(clk_i), .rx_o(rx), .valid_o(fv), .ident_o(fid), .ext_o(fx));
	can_wake_id_filter #(.TIMEOUT_CYCLES(50), .HOLD_DEPTH(4)) u_dut (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .bit_div_i(div), .normal_mode_i(nrm),
		.wake_mode_i(mode), .ident_value_i(idv), .ident_value_ext_i(idx),
		.ident_compare_mask_i(msk), .ident_mask_ext_i(mkx), .can_rx_i(rx),
		.ctrl_tx_i(1'b0), .ctrl_tx_en_i(txe), .can_tx_o(can_tx), .bit_tick_o(tick),
		.rx_sample_o(rxs), .frame_valid_i(fv), .frame_ident_i(fid), .frame_ext_i(fx),
		.ignition_i(ign), .other_wake_i(oth), .logger_ready_i(ready),
		.alert_ack_i(ack), .logger_on_o(on), .shutdown_ok_o(sok), .any_wake_source_o(aws),
		.cap_valid_o(capv), .cap_data_o(capd), .log_entry_o(logd), .alert_o(alert));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic pulse_ack();
		ack = 1'b1;
		cyc(1);
		ack = 1'b0;
		cyc(1);
	endtask
	// run the logger until it times out, then acknowledge the alert
	task automatic retire();
		ready = 1'b1;
		n = 0;
		while (!logd && n < 200)
		begin
			cyc(1);
			n++;
		end
		chk(n > 44 && n < 60, 1);
		cyc(1);
		chk(on, 0);
		chk(sok, 1);
		cyc(3);
		chk(alert, 1);
		pulse_ack();
		chk(alert, 0);
		ready = 1'b0;
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		#50us;
		bad_count++;
		print_verdict();
	end
	initial
	begin
		{reset_n_i, nrm, ready, ack, ign, idx, mkx} = 7'h00;
		txe = 1'b1;
		oth = 1'b0;
		div = 16'h000C;
		mode = 2'h0;
		idv = 29'h00000016;
		msk = 29'h0000001C;
		repeat (16) @(posedge clk_i);
		#1;
		chk(sok, 1);
		chk(can_tx, 1);
		reset_n_i = 1'b1;
		@(posedge tick);
		t = $time;
		@(posedge tick);
		chk(32'(($time - t) / 10), 12);
		t = $time;
		#1 div = 16'h0008;
		@(posedge tick);
		chk(32'(($time - t) / 10), 8);
		u_node.drive_rx(1'b0);
		cyc(10);
		chk(rxs, 0);
		u_node.drive_rx(1'b1);
		cyc(10);
		chk(rxs, 1);
		cyc(20);
		chk(can_tx, 1);
		nrm = 1'b1;
		cyc(20);
		chk(can_tx, 0);
		nrm = 1'b0;
		u_node.send(29'h00000115, 1'b0);
		cyc(2);
		chk(on, 0);
		mode = 2'h1;
		u_node.send(29'h00000119, 1'b0);
		cyc(2);
		chk(on, 0);
		u_node.send(29'h00000115, 1'b0);
		chk(capv, 0);
		cyc(1);
		chk(on, 1);
		retire();
		msk = 29'h00000000;
		u_node.send(29'h000007FF, 1'b0);
		cyc(1);
		chk(on, 1);
		chk(sok, 0);
		ready = 1'b1;
		cyc(2);
		u_node.send(29'h00000123, 1'b0);
		chk(capv, 1);
		chk(capd, {1'b0, 29'h00000123});
		retire();
		{mode, idx, mkx} = 4'hB;
		msk = 29'h1FFFFFFF;
		idv = 29'h1ABCDE01;
		u_node.send(idv, 1'b0);
		cyc(2);
		chk(on, 0);
		u_node.send(idv, 1'b1);
		ready = 1'b1;
		u_node.send(29'h00000055, 1'b1);
		n = 0;
		while (!capv && n < 50)
		begin
			cyc(1);
			n++;
		end
		chk(capd, {1'b1, idv});
		cyc(1);
		chk(capv, 1);
		chk(capd, {1'b1, 29'h00000055});
		retire();
		mode = 2'h3;
		ign = 1'b1;
		cyc(3);
		chk(on, 1);
		chk(aws, 1);
		ign = 1'b0;
		oth = 1'b1;
		ready = 1'b1;
		cyc(70);
		chk(on, 1);
		oth = 1'b0;
		cyc(3);
		chk(on, 0);
		chk(aws, 0);
		pulse_ack();
		print_verdict();
	end
endmodule
